// File: trig_src_pkg.sv
package trig_src_pkg;

  // Line selector values
  localparam logic [15:0] SEL_TTL_FIRST   = 16'h0000;
  localparam logic [15:0] SEL_TTL_LAST    = 16'h0007;
  localparam logic [15:0] SEL_ECL_FIRST   = 16'h0008;
  localparam logic [15:0] SEL_ECL_LAST    = 16'h000D;
  localparam logic [15:0] SEL_GPIO_FIRST  = 16'h0028;
  localparam logic [15:0] SEL_GPIO_LAST   = 16'h0031;
  localparam logic [15:0] SEL_COUNTER     = 16'h0032;
  localparam logic [15:0] SEL_TICK        = 16'h003C;
  localparam logic [15:0] SEL_ALL_LINES   = 16'hFFFF;

  // Source protocol codes
  localparam logic [15:0] PROT_ON         = 16'h0000;
  localparam logic [15:0] PROT_OFF        = 16'h0001;
  localparam logic [15:0] PROT_START      = 16'h0002;
  localparam logic [15:0] PROT_STOP       = 16'h0003;
  localparam logic [15:0] PROT_SYNC       = 16'h0004;
  localparam logic [15:0] PROT_SEMI       = 16'h0005;
  localparam logic [15:0] PROT_ASYNC      = 16'h0006;
  localparam logic [15:0] PROT_SEMI_ACK   = 16'h0007;
  localparam logic [15:0] PROT_ASYNC_ACK  = 16'h0008;
  localparam logic [15:0] PROT_ABORT      = 16'hFFFF;

  // Assertion mode bit positions and legal mask
  localparam int          MODE_FALL_BIT   = 0;
  localparam int          MODE_ASYNC_BIT  = 1;
  localparam int          MODE_SEMI_BIT   = 2;
  localparam logic [15:0] MODE_LEGAL_MASK = 16'h0007;

  // Return status codes
  localparam logic [15:0] ST_OK           = 16'h0000;
  localparam logic [15:0] ST_BAD_LINE     = 16'hFFFD;  // -3
  localparam logic [15:0] ST_PROT_UNSUP   = 16'hFFFB;  // -5
  localparam logic [15:0] ST_TIMEOUT      = 16'hFFFA;  // -6
  localparam logic [15:0] ST_IN_USE       = 16'hFFF9;  // -7
  localparam logic [15:0] ST_BAD_MODE     = 16'hFFF6;  // -10
  localparam logic [15:0] ST_NOT_CONFIG   = 16'hFFF4;  // -12
  localparam logic [15:0] ST_INCOMPLETE   = 16'hFFF1;  // -15
  localparam logic [15:0] ST_ACK_PENDING  = 16'hFFF0;  // -16

  // Resource counts
  localparam int          NUM_TRIG        = 14;
  localparam int          NUM_GPIO        = 10;
  localparam int          NUM_IRQ_SRC     = 16;
  localparam int          IRQ_COUNTER_BIT = 14;
  localparam int          IRQ_TICK_BIT    = 15;

  // Timing: one millisecond of core clock
  localparam int          CLK_MHZ         = 250;
  localparam int          MS_IN_US        = 1000;
  localparam int          CYCLES_PER_MS   = CLK_MHZ * MS_IN_US;

  // Source operation states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_PULSE, ST_WAIT_ACK} src_state_t;

endpackage

// File: ms_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

// Millisecond tick shared between timer and source engine
interface ms_tick_if;
  logic tick;
  logic run;
  modport timer (input run, output tick);
  modport user  (output run, input tick);
endinterface // ms_tick_if

`default_nettype wire

// File: ms_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ms_timer
  import trig_src_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Tick carrier
  ms_tick_if.timer  tk
);

  logic [31:0] count;

  // Prescaler restarts whenever the wait is idle so each ms is whole
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count   <= 32'h00000000;
      tk.tick <= 1'b0;
    end else if (!tk.run) begin
      count   <= 32'h00000000;
      tk.tick <= 1'b0;
    end else if (count == 32'(CYCLES_MS - 1)) begin
      count   <= 32'h00000000;
      tk.tick <= 1'b1;
    end else begin
      count   <= count + 32'h00000001;
      tk.tick <= 1'b0;
    end
  end

endmodule // ms_timer

`default_nettype wire

// File: trigger_line_source_control.sv
// What this block does
// - Selector 0-7 picks TTL lines, 8-13 picks ECL lines.
// - Selector 40-49 picks GPIO 0-9; only ON, OFF, START, STOP, SYNC.
// - Selector 50 counter, 60 tick timers; only SYNC and SEMI-SYNC.
// - Protocol codes: 0 ON,1 OFF,2 START,3 STOP,4 SYNC,5 SEMI,6 ASYNC.
// - Codes 7 and 8 source SEMI/ASYNC then wait for acknowledge.
// - Protocol all ones aborts a pending acknowledge wait.
// - No acknowledge within timeout milliseconds ends wait with timeout status.
// - New request during outstanding acknowledge refused with pending status.
// - Request on a line claimed elsewhere refused with in-use status.
// - Request on unconfigured line refused with not-configured status.
// - Request while previous operation unfinished refused with incomplete status.
// - Mode bit 0 picks falling CLK10 edge when set, rising when clear.
// - Configuration selector all ones applies to every TTL and ECL line.
// - Mode bit 1 passes through asynchronously; clear syncs every protocol except ON and OFF to CLK10 edge.
// - Mode bit 2 enables SEMI-SYNC participation with external acknowledge; only stored in cfg_semi_part, the engine never reads it.
// - Mode values with reserved bits rejected with invalid-mode status.
// - Sixteen-bit interrupt select: 0-13 lines, 14 counter, 15 tick timers.
`timescale 1ns/1ps
`default_nettype none

module trigger_line_source_control
  import trig_src_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Backplane reference clock, sampled as a level
  input  wire logic                   clk10,
  // Source request
  input  wire logic                   src_req,
  input  wire logic [15:0]            src_line,
  input  wire logic [15:0]            src_prot,
  input  wire logic [31:0]            src_timeout_ms,
  // Assertion configuration request
  input  wire logic                   cfg_req,
  input  wire logic [15:0]            cfg_line,
  input  wire logic [15:0]            cfg_mode,
  // Per-line enables and claims from neighbouring logic
  input  wire logic [NUM_TRIG-1:0]    trig_src_enable,
  input  wire logic [NUM_GPIO-1:0]    gpio_src_enable,
  input  wire logic [NUM_TRIG-1:0]    trig_claimed,
  input  wire logic                   cntr_busy,
  input  wire logic                   tick_busy,
  // Trigger line levels and acknowledge
  input  wire logic [NUM_TRIG-1:0]    trig_in,
  input  wire logic                   ext_ack,
  // Interrupt source selection
  input  wire logic                   irq_sel_we,
  input  wire logic [NUM_IRQ_SRC-1:0] irq_sel_wdata,
  // Trigger line drive (open-collector style)
  output logic      [NUM_TRIG-1:0]    trig_out,
  output logic      [NUM_TRIG-1:0]    trig_oe,
  output logic      [NUM_GPIO-1:0]    gpio_out,
  output logic      [NUM_GPIO-1:0]    gpio_oe,
  output logic                        cntr_start,
  output logic                        tick_start,
  // Status
  output logic                        done,
  output logic      [15:0]            status,
  output logic                        ack_pending,
  output logic      [NUM_TRIG-1:0]    cfg_fall_edge,
  output logic                        cfg_async,
  output logic      [NUM_TRIG-1:0]    cfg_semi_part,
  output logic      [NUM_IRQ_SRC-1:0] irq_sel
);

  ms_tick_if tk();

  ms_timer #(.CYCLES_MS(CYCLES_MS)) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tk       (tk.timer)
  );

  src_state_t  state;
  logic        clk10_q;
  logic        edge_rise;
  logic        edge_fall;
  logic [15:0] act_line;
  logic [15:0] act_prot;
  logic [31:0] ms_left;
  logic        ack_wait;
  logic        ack_q;
  logic        is_trig;
  logic        is_gpio;
  logic        is_cntr;
  logic        is_tick;
  logic [3:0]  trig_idx;
  logic [3:0]  gpio_idx;
  logic [15:0] next_check;
  logic        act_trig;
  logic [3:0]  act_idx;
  logic        edge_hit;

  // Edge detection on CLK10 sampled by core clock
  // CLK10 is far slower, so one sample per half period is plenty
  // Reset loads clk10_q low, so a CLK10 high at reset release shows a false rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk10_q <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      clk10_q <= clk10;
      ack_q   <= ext_ack;
    end
  end
  assign edge_rise = clk10 & ~clk10_q;
  assign edge_fall = ~clk10 & clk10_q;

  assign is_trig  = (src_line <= SEL_ECL_LAST);
  assign is_gpio  = (src_line >= SEL_GPIO_FIRST) && (src_line <= SEL_GPIO_LAST);
  assign is_cntr  = (src_line == SEL_COUNTER);
  assign is_tick  = (src_line == SEL_TICK);
  assign trig_idx = src_line[3:0];
  assign gpio_idx = 4'(src_line - SEL_GPIO_FIRST);

  // Request checking; earlier checks take priority
  // Line and protocol faults come before enables and claims,
  // so a malformed request never reports a resource status
  always_comb begin
    next_check = ST_OK;
    if (!(is_trig || is_gpio || is_cntr || is_tick)) begin
      next_check = ST_BAD_LINE;
    end else if (src_prot > PROT_ASYNC_ACK) begin
      next_check = ST_BAD_LINE;
    end else if (is_gpio && src_prot > PROT_SYNC) begin
      next_check = ST_PROT_UNSUP;
    end else if ((is_cntr || is_tick) && src_prot != PROT_SYNC && src_prot != PROT_SEMI) begin
      next_check = ST_PROT_UNSUP;
    end else if ((is_trig && !trig_src_enable[trig_idx]) || (is_gpio && !gpio_src_enable[gpio_idx])) begin
      next_check = ST_NOT_CONFIG;
    end else if ((is_trig && trig_claimed[trig_idx]) || (is_cntr && cntr_busy) || (is_tick && tick_busy)) begin
      next_check = ST_IN_USE;
    end
  end

  assign act_trig    = (act_line <= SEL_ECL_LAST);
  assign act_idx     = act_line[3:0];
  assign edge_hit    = cfg_fall_edge[act_idx] ? edge_fall : edge_rise;
  assign tk.run      = ack_wait;

  // Source engine: one operation at a time
  // Abort ends only an acknowledge wait; in any other state it just answers done with OK status
  // Acknowledge wins over a timer tick falling in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      act_line    <= 16'h0000;
      act_prot    <= 16'h0000;
      ms_left     <= 32'h00000000;
      ack_wait    <= 1'b0;
      ack_pending <= 1'b0;
      done        <= 1'b0;
      status      <= ST_OK;
      cntr_start  <= 1'b0;
      tick_start  <= 1'b0;
    end else begin
      done       <= 1'b0;
      cntr_start <= 1'b0;
      tick_start <= 1'b0;
      if (src_req && src_prot == PROT_ABORT) begin
        if (ack_wait) begin
          ack_wait    <= 1'b0;
          ack_pending <= 1'b0;
          state       <= ST_IDLE;
        end
        done   <= 1'b1;
        status <= ST_OK;
      end else if (src_req && ack_wait) begin
        done   <= 1'b1;
        status <= ST_ACK_PENDING;
      end else if (src_req && state != ST_IDLE) begin
        done   <= 1'b1;
        status <= ST_INCOMPLETE;
      end else if (src_req && next_check != ST_OK) begin
        done   <= 1'b1;
        status <= next_check;
      end else if (src_req) begin
        act_line <= src_line;
        act_prot <= src_prot;
        ms_left  <= src_timeout_ms;
        if (is_cntr || is_tick) begin
          cntr_start <= is_cntr;
          tick_start <= is_tick;
          done       <= 1'b1;
          status     <= ST_OK;
        end else if (is_trig && !cfg_async && src_prot != PROT_ON && src_prot != PROT_OFF) begin
          state <= ST_WAIT_EDGE;
        end else begin
          state <= ST_PULSE;
        end
      end else begin
        case (state)
          ST_WAIT_EDGE: begin
            if (edge_hit) begin
              state <= ST_PULSE;
            end
          end
          ST_PULSE: begin
            if (act_prot == PROT_SEMI_ACK || act_prot == PROT_ASYNC_ACK) begin
              state       <= ST_WAIT_ACK;
              ack_wait    <= 1'b1;
              ack_pending <= 1'b1;
            end else begin
              state  <= ST_IDLE;
              done   <= 1'b1;
              status <= ST_OK;
            end
          end
          ST_WAIT_ACK: begin
            if (ack_q || (act_trig && trig_in[act_idx])) begin
              state       <= ST_IDLE;
              ack_wait    <= 1'b0;
              ack_pending <= 1'b0;
              done        <= 1'b1;
              status      <= ST_OK;
            end else if (tk.tick) begin
              // Timeout 0 and 1 both end at the first millisecond tick
              if (ms_left <= 32'h00000001) begin
                state       <= ST_IDLE;
                ack_wait    <= 1'b0;
                ack_pending <= 1'b0;
                done        <= 1'b1;
                status      <= ST_TIMEOUT;
              end else begin
                ms_left <= ms_left - 32'h00000001;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Line drive per protocol; ON/START hold, SYNC/SEMI/ASYNC last one cycle, codes 7 and 8 hold until the acknowledge wait ends
  // Trigger lines are open-collector: trig_out stays low and only oe moves; GPIO lines drive gpio_out
  // A held ON/START line ignores other trigger lines but is released by a GPIO, counter or tick SYNC/SEMI request with its low four bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TRIG; gi++) begin : g_trig
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          trig_oe[gi]  <= 1'b0;
          trig_out[gi] <= 1'b0;
        end else if (state == ST_PULSE && act_trig && act_idx == 4'(gi)) begin
          trig_out[gi] <= 1'b0;
          trig_oe[gi]  <= (act_prot == PROT_ON) || (act_prot == PROT_START) ||
                          (act_prot >= PROT_SYNC && act_prot <= PROT_ASYNC_ACK);
        end else if (trig_oe[gi] && act_idx == 4'(gi) && act_prot >= PROT_SYNC && state != ST_WAIT_ACK) begin
          // Release after pulse or acknowledge
          trig_oe[gi] <= 1'b0;
        end
      end
    end
    for (gi = 0; gi < NUM_GPIO; gi++) begin : g_gpio
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          gpio_oe[gi]  <= 1'b0;
          gpio_out[gi] <= 1'b0;
        end else if (state == ST_PULSE && act_line == SEL_GPIO_FIRST + 16'(gi)) begin
          gpio_oe[gi]  <= 1'b1;
          gpio_out[gi] <= (act_prot == PROT_ON) || (act_prot == PROT_START) || (act_prot == PROT_SYNC);
        end else if (gpio_oe[gi] && act_prot == PROT_SYNC && act_line == SEL_GPIO_FIRST + 16'(gi)) begin
          gpio_out[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Assertion configuration
  // A source request in the same cycle wins; config must be retried
  // Async pass bit is global even when written through one line
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_fall_edge <= '0;
      cfg_async     <= 1'b0;
      cfg_semi_part <= '0;
    end else if (cfg_req && !src_req && (cfg_mode & ~MODE_LEGAL_MASK) == 16'h0000) begin
      if (cfg_line == SEL_ALL_LINES) begin
        cfg_fall_edge <= {NUM_TRIG{cfg_mode[MODE_FALL_BIT]}};
        cfg_async     <= cfg_mode[MODE_ASYNC_BIT];
        cfg_semi_part <= {NUM_TRIG{cfg_mode[MODE_SEMI_BIT]}};
      end else if (cfg_line <= SEL_ECL_LAST) begin
        cfg_fall_edge[cfg_line[3:0]] <= cfg_mode[MODE_FALL_BIT];
        cfg_async                    <= cfg_mode[MODE_ASYNC_BIT];
        cfg_semi_part[cfg_line[3:0]] <= cfg_mode[MODE_SEMI_BIT];
      end
    end
  end

  // Write replaces the whole vector; no read-modify-write needed
  // Interrupt source select
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_sel <= '0;
    end else if (irq_sel_we) begin
      irq_sel <= irq_sel_wdata;
    end
  end

  // Configuration result is kept internally; no port or logic reads it out
  // An out-of-range line is flagged apart from a reserved mode bit
  // Reserved mode bits or out-of-range line
  logic cfg_bad;
  assign cfg_bad = cfg_req && !src_req && ((cfg_mode & ~MODE_LEGAL_MASK) != 16'h0000 ||
                   (cfg_line > SEL_ECL_LAST && cfg_line != SEL_ALL_LINES));
  logic [15:0] cfg_status;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_status <= ST_OK;
    end else if (cfg_bad) begin
      cfg_status <= ((cfg_mode & ~MODE_LEGAL_MASK) != 16'h0000) ? ST_BAD_MODE : ST_BAD_LINE;
    end else if (cfg_req) begin
      cfg_status <= ST_OK;
    end
  end

endmodule // trigger_line_source_control

`default_nettype wire

// File: tlsc_props.sv
`timescale 1ns/1ps
`default_nettype none

module tlsc_props
  import trig_src_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // Requests
  input wire logic                   src_req,
  input wire logic [15:0]            src_line,
  input wire logic [15:0]            src_prot,
  input wire logic                   cfg_req,
  input wire logic [15:0]            cfg_line,
  input wire logic [15:0]            cfg_mode,
  input wire logic [NUM_TRIG-1:0]    trig_src_enable,
  input wire logic                   cntr_busy,
  input wire logic                   tick_busy,
  input wire logic                   irq_sel_we,
  input wire logic [NUM_IRQ_SRC-1:0] irq_sel_wdata,
  // Results
  input wire logic [NUM_TRIG-1:0]    trig_oe,
  input wire logic                   done,
  input wire logic [15:0]            status,
  input wire logic                   ack_pending,
  input wire logic [NUM_TRIG-1:0]    cfg_fall_edge,
  input wire logic                   cfg_async,
  input wire logic [NUM_TRIG-1:0]    cfg_semi_part,
  input wire logic [NUM_IRQ_SRC-1:0] irq_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Request free of wait and busy refusals, so lower codes show
  logic go;
  assign go = src_req && !ack_pending && !cntr_busy && !tick_busy;

  a_reset_idle: assert property ($fell(rst) |-> trig_oe == '0 && !cfg_async && cfg_semi_part == '0
    && cfg_fall_edge == '0) else $error("not idle after reset");
  a_ack_refuse: assert property (src_req && ack_pending && src_prot != PROT_ABORT
    |=> done && status == ST_ACK_PENDING) else $error("pending request not refused");
  a_abort_clear: assert property (src_req && ack_pending && src_prot == PROT_ABORT
    |=> done && status == ST_OK ##[0:2] !ack_pending) else $error("abort failed");
  a_line_range: assert property (go && src_line > SEL_ECL_LAST && src_line < SEL_GPIO_FIRST
    |=> done && status == ST_BAD_LINE) else $error("gap line accepted");
  a_bad_prot: assert property (go && src_prot > PROT_ASYNC_ACK && src_prot != PROT_ABORT
    |=> done && status == ST_BAD_LINE) else $error("bad protocol accepted");
  a_not_config: assert property (go && src_line <= SEL_ECL_LAST && src_prot <= PROT_ASYNC_ACK
    && !trig_src_enable[src_line[3:0]] |=> done && status == ST_NOT_CONFIG) else $error("unconfigured line");
  a_gpio_prot: assert property (go && src_line >= SEL_GPIO_FIRST && src_line <= SEL_GPIO_LAST
    && src_prot >= PROT_SEMI && src_prot <= PROT_ASYNC_ACK |=> done && status == ST_PROT_UNSUP)
    else $error("gpio protocol accepted");
  a_cntr_prot: assert property (go && src_line == SEL_COUNTER && (src_prot < PROT_SYNC
    || src_prot == PROT_ASYNC) |=> done && status == ST_PROT_UNSUP) else $error("counter protocol accepted");
  a_irq_write: assert property (irq_sel_we |=> irq_sel == $past(irq_sel_wdata))
    else $error("interrupt select not written");
  a_mode_reserved: assert property (cfg_req && !src_req && (cfg_mode & ~MODE_LEGAL_MASK) != '0
    |=> $stable(cfg_fall_edge) && $stable(cfg_async) && $stable(cfg_semi_part)) else $error("reserved mode used");
  a_all_fall: assert property (cfg_req && !src_req && cfg_line == SEL_ALL_LINES && cfg_mode == 16'h0001
    |-> ##[1:2] cfg_fall_edge == '1 && !cfg_async) else $error("global config missed");

  // Main scenarios
  c_ack_ok: cover property (ack_pending ##[1:300] done && status == ST_OK);
  c_timeout: cover property (done && status == ST_TIMEOUT);
  c_async_on: cover property ($rose(cfg_async));
endmodule // tlsc_props

bind trigger_line_source_control tlsc_props #(.CYCLES_MS(CYCLES_MS)) i_tlsc_props (
  .core_clk, .rst, .src_req, .src_line, .src_prot, .cfg_req, .cfg_line, .cfg_mode,
  .trig_src_enable, .cntr_busy, .tick_busy, .irq_sel_we, .irq_sel_wdata, .trig_oe, .done,
  .status, .ack_pending, .cfg_fall_edge, .cfg_async, .cfg_semi_part, .irq_sel);

`default_nettype wire

// File: backplane_peer.sv
`timescale 1ns/1ps
`default_nettype none

module backplane_peer
  import trig_src_pkg::*;
#(
  parameter int DLY  = 6,
  parameter int HOLD = 3
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Bench control and line drive
  input  wire logic                ack_on,
  input  wire logic [NUM_TRIG-1:0] trig_oe,
  // Acknowledge back to the block
  output logic                     ext_ack,
  output logic [NUM_TRIG-1:0]      trig_in
);
  logic [7:0]          cnt;
  logic [NUM_TRIG-1:0] prev;
  logic [NUM_TRIG-1:0] mask;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      prev <= '0;
      mask <= '0;
    end else begin
      prev <= trig_oe;
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (ack_on && |(trig_oe & ~prev)) begin
        cnt  <= 8'(DLY + HOLD);
        mask <= trig_oe & ~prev;
      end
    end
  end

  // Released lines read idle, not the last asserted value
  assign ext_ack = cnt != 8'h00 && cnt <= 8'(HOLD);
  assign trig_in = ext_ack ? mask : '0;
endmodule // backplane_peer

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import trig_src_pkg::*;
  localparam int N = 17;
  localparam logic [15:0] TL [N] = '{16'h000E, 16'h0027, 16'h0000, 16'h0009, 16'h0002, 16'h0028, 16'h0031,
    16'h002D, 16'h0032, 16'h003C, 16'h003C, 16'h000D, 16'h0008, 16'h0029, 16'h0029, 16'h0029, 16'h0029};
  localparam logic [15:0] TP [N] = '{PROT_ON, PROT_SYNC, 16'h0009, PROT_SYNC, PROT_SYNC, PROT_SEMI,
    PROT_ASYNC_ACK, PROT_SYNC, PROT_ON, PROT_ASYNC, PROT_SYNC, PROT_ASYNC, PROT_SEMI, PROT_ON, PROT_OFF,
    PROT_START, PROT_STOP};
  localparam logic [15:0] TE [N] = '{ST_BAD_LINE, ST_BAD_LINE, ST_BAD_LINE, ST_NOT_CONFIG, ST_IN_USE,
    ST_PROT_UNSUP, ST_PROT_UNSUP, ST_OK, ST_PROT_UNSUP, ST_PROT_UNSUP, ST_OK, ST_OK, ST_OK, ST_OK, ST_OK,
    ST_OK, ST_OK};
  logic core_clk, rst, clk10, src_req, cfg_req, irq_sel_we, cntr_busy, tick_busy, ext_ack, ack_on;
  logic done, cfg_async, ack_pending, cntr_start, tick_start;
  logic [15:0]         src_line, src_prot, cfg_line, cfg_mode, irq_sel_wdata, status, irq_sel;
  logic [31:0]         src_timeout_ms;
  logic [NUM_TRIG-1:0] trig_src_enable, trig_claimed, trig_in, trig_out, trig_oe, cfg_fall_edge;
  logic [NUM_TRIG-1:0] cfg_semi_part, oe_at_done;
  logic                clk_at_done;
  logic [1:0]          strt_at_done;
  int                  wait_cycles;
  logic [NUM_GPIO-1:0] gpio_src_enable, gpio_out, gpio_oe;
  int                  num_errors = 0;
  int                  check_count = 0;

  trigger_line_source_control #(.CYCLES_MS(10)) i_trigger_line_source_control (
    .core_clk, .rst, .clk10, .src_req, .src_line, .src_prot, .src_timeout_ms, .cfg_req, .cfg_line,
    .cfg_mode, .trig_src_enable, .gpio_src_enable, .trig_claimed, .cntr_busy, .tick_busy, .trig_in,
    .ext_ack, .irq_sel_we, .irq_sel_wdata, .trig_out, .trig_oe, .gpio_out, .gpio_oe, .cntr_start,
    .tick_start, .done, .status, .ack_pending, .cfg_fall_edge, .cfg_async, .cfg_semi_part, .irq_sel);
  backplane_peer i_backplane_peer (.core_clk, .rst, .ack_on, .trig_oe, .ext_ack, .trig_in);

  // Core clock and a free running backplane clock of unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    clk10 = 1'b0;
    #13.7;
    forever #50 clk10 = ~clk10;
  end

  task automatic cmp_st(input logic [15:0] exp);
    check_count++;
    if (status !== exp || done !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: status %h expected %h", $time, status, exp);
    end
  endtask

  task automatic cmp_bits(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: level %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic req(input logic [15:0] l, input logic [15:0] p, input logic [31:0] t);
    @(posedge core_clk);
    #1;
    src_req = 1'b1;
    src_line = l;
    src_prot = p;
    src_timeout_ms = t;
    @(posedge core_clk);
    #1;
    src_req = 1'b0;
  endtask

  // Bounded wait for the answer; oe is captured in the done cycle
  task automatic src(input logic [15:0] l, input logic [15:0] p, input logic [31:0] t, input logic [15:0] e);
    int i;
    req(l, p, t);
    for (i = 0; i < 4000 && done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    oe_at_done = trig_oe;
    wait_cycles = i;
    clk_at_done = clk10;
    strt_at_done = {cntr_start, tick_start};
    cmp_st(e);
  endtask

  task automatic cfg(input logic [15:0] l, input logic [15:0] m);
    @(posedge core_clk);
    #1;
    cfg_req = 1'b1;
    cfg_line = l;
    cfg_mode = m;
    @(posedge core_clk);
    #1;
    cfg_req = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Watchdog sized well beyond the whole sequence
  initial begin
    #160000;
    num_errors++;
    wrap_up();
  end

  initial begin
    {rst, src_req, cfg_req, irq_sel_we, cntr_busy, tick_busy, ack_on} = 7'h40;
    {src_line, src_prot, cfg_line, cfg_mode, irq_sel_wdata, src_timeout_ms} = '0;
    trig_src_enable = 14'h3DFF;
    trig_claimed = 14'h0004;
    gpio_src_enable = '1;
    idle(12);
    rst = 1'b0;
    cmp_bits(16'({cfg_async, cfg_semi_part, trig_oe, cfg_fall_edge}), 16'h0000);
    cfg(16'hFFFF, 16'h0001);
    cmp_bits(16'(cfg_fall_edge), 16'h3FFF);
    cfg(16'h0003, 16'h0000);
    cmp_bits(16'(cfg_fall_edge), 16'h3FF7);
    cfg(16'hFFFF, 16'h0009);
    cmp_bits(16'(cfg_fall_edge), 16'h3FF7);
    cfg(16'h0005, 16'h0004);
    cmp_bits(16'(cfg_semi_part), 16'h0020);
    cfg(16'h0005, 16'h0002);
    cmp_bits(16'(cfg_async), 16'h0001);
    cfg(16'hFFFF, 16'h0000);
    cmp_bits(16'({cfg_async, cfg_semi_part, cfg_fall_edge}), 16'h0000);
    for (int k = 0; k < N; k++) src(TL[k], TP[k], 0, TE[k]);
    for (int k = 0; k < 2; k++) begin
      src(16'h0000, 16'(2 * k), 0, ST_OK);
      idle(3);
      cmp_bits(16'(trig_oe), 16'h0001);
      src(16'h0000, 16'(2 * k + 1), 0, ST_OK);
      idle(3);
      cmp_bits(16'(trig_oe), 16'h0000);
    end
    src(16'h0004, PROT_SYNC, 0, ST_OK);
    cmp_bits(16'(oe_at_done), 16'h0010);
    cmp_bits(16'(clk_at_done), 16'h0001);
    req(16'h0004, PROT_SYNC, 0);
    src(16'h0005, PROT_SYNC, 0, ST_INCOMPLETE);
    idle(30);
    cfg(16'h0004, 16'h0001);
    src(16'h0004, PROT_SYNC, 0, ST_OK);
    cmp_bits(16'(clk_at_done), 16'h0000);
    cfg(16'h0004, 16'h0002);
    src(16'h0004, PROT_SYNC, 0, ST_OK);
    cmp_bits(16'(wait_cycles), 16'h0001);
    cfg(16'hFFFF, 16'h0000);
    src(SEL_COUNTER, PROT_SEMI, 0, ST_OK);
    cmp_bits(16'(strt_at_done), 16'h0002);
    src(16'h0029, PROT_START, 0, ST_OK);
    cmp_bits(16'({gpio_oe[1], gpio_out}), 16'h0402);
    src(16'h0029, PROT_STOP, 0, ST_OK);
    cmp_bits(16'(gpio_out), 16'h0000);
    cntr_busy = 1'b1;
    src(SEL_COUNTER, PROT_SYNC, 0, ST_IN_USE);
    cntr_busy = 1'b0;
    ack_on = 1'b1;
    src(16'h0006, PROT_SEMI_ACK, 5, ST_OK);
    src(16'h0007, PROT_ASYNC_ACK, 5, ST_OK);
    ack_on = 1'b0;
    idle(12);
    src(16'h0006, PROT_ASYNC_ACK, 2, ST_TIMEOUT);
    req(16'h0006, PROT_SEMI_ACK, 20);
    idle(40);
    cmp_bits(16'(ack_pending), 16'h0001);
    src(16'h0003, PROT_SYNC, 0, ST_ACK_PENDING);
    cmp_bits(16'(trig_oe[3]), 16'h0000);
    src(16'h0006, PROT_ABORT, 0, ST_OK);
    idle(3);
    cmp_bits(16'(ack_pending), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      #1;
      irq_sel_we = 1'b1;
      irq_sel_wdata = k ? 16'h3FFA : 16'hC005;
      idle(1);
      irq_sel_we = 1'b0;
      idle(1);
      cmp_bits(irq_sel, k ? 16'h3FFA : 16'hC005);
    end
    wrap_up();
  end
endmodule // tb

`default_nettype wire
